// ### verilog/els_pkg.sv
// Constants of the E1 line event status block: register indexes, field positions,
// reset values and limits. Assumes a 32-bit APB master; byte address = index * 4.
package els_pkg;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned BYTE_SHIFT   = 2;
    localparam int unsigned INDEX_W      = ADDR_W - BYTE_SHIFT;
    localparam logic [9:0]  IDX_ENABLE   = 10'h034;
    localparam logic [9:0]  IDX_FLAGS    = 10'h03b;
    localparam logic [9:0]  IDX_COUNT_HI = 10'h03c;
    localparam logic [9:0]  IDX_COUNT_LO = 10'h03d;
    localparam logic [9:0]  IDX_REF_CTRL = 10'h03e;
    localparam logic [9:0]  IDX_LINE_IND = 10'h03f;
    localparam logic [9:0]  IDX_FRM_IND  = 10'h040;
    localparam logic [9:0]  IDX_LINK_IND = 10'h041;
    localparam int unsigned BIT_TEMPLATE = 6;
    localparam int unsigned BIT_TX_FIFO  = 5;
    localparam int unsigned BIT_RX_FIFO  = 4;
    localparam int unsigned BIT_ZERO     = 2;
    localparam int unsigned BIT_VIOL     = 1;
    localparam int unsigned BIT_CNTOV    = 0;
    localparam int unsigned BIT_REF_SEL  = 0;
    localparam int unsigned BIT_LINE_IND = 0;
    localparam int unsigned BIT_ALARM    = 5;
    localparam logic [7:0]  FLAG_MASK    = 8'h77;
    localparam logic [7:0]  ENABLE_MASK  = 8'h77;
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [7:0]  REF_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hffff;
    localparam logic [15:0] COUNT_STEP   = 16'h0001;
    localparam int unsigned SUM_W        = 10;
    localparam logic signed [9:0] DAC_LIMIT = 10'sd63;
endpackage

// ### verilog/els_line_event_status.sv
// E1 line event status block: sticky line error flags, zero error counter,
// interrupt enable and pin, reference clock selection and module indications.
// Assumes an APB master on CLK and event inputs synchronous to CLK.
`timescale 1ns/1ps
module els_line_event_status (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [els_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]                PWDATA,
    input  wire logic [3:0]                 PSTRB,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire logic                       TEMPLATE_CHECK,
    input  wire logic                       TEMPLATE_MULTI_UI,
    input  wire logic signed [els_pkg::SUM_W-1:0] TEMPLATE_SUM,
    input  wire logic                       TX_FIFO_OVERFLOW,
    input  wire logic                       TX_FIFO_UNDERFLOW,
    input  wire logic                       RX_FIFO_OVERFLOW,
    input  wire logic                       RX_FIFO_UNDERFLOW,
    input  wire logic                       EXCESS_ZEROS,
    input  wire logic                       BIPOLAR_VIOLATION,
    input  wire logic                       CODE_VIOLATION,
    input  wire logic                       LOSS_OF_SIGNAL,
    input  wire logic                       MASTER_CLOCK,
    output logic                            REFERENCE_CLOCK_OUTPUT,
    input  wire logic [7:0]                 LINE_SUB_IRQ,
    input  wire logic                       ALARM_IRQ,
    input  wire logic [4:0]                 FRAMER_IRQ,
    input  wire logic [7:0]                 LINK_IRQ,
    output logic                            IRQ
);
    logic [7:0]  flags;
    logic [7:0]  enable;
    logic [7:0]  ref_ctrl;
    logic [15:0] zero_count;
    logic [7:0]  next_flags;
    logic [15:0] next_count;

    // Address decode; registers sit on aligned words only
    logic [els_pkg::INDEX_W-1:0] reg_index;
    logic aligned;
    logic hit_enable;
    logic hit_flags;
    logic hit_cnt_hi;
    logic hit_cnt_lo;
    logic hit_ref;
    logic hit_line;
    logic hit_frm;
    logic hit_link;
    logic mapped;
    logic setup_phase;
    logic access_phase;
    logic write_taken;

    assign reg_index    = PADDR[els_pkg::ADDR_W-1:els_pkg::BYTE_SHIFT];
    assign aligned      = (PADDR[els_pkg::BYTE_SHIFT-1:0] == 2'h0);
    assign hit_enable   = aligned & (reg_index == els_pkg::IDX_ENABLE);
    assign hit_flags    = aligned & (reg_index == els_pkg::IDX_FLAGS);
    assign hit_cnt_hi   = aligned & (reg_index == els_pkg::IDX_COUNT_HI);
    assign hit_cnt_lo   = aligned & (reg_index == els_pkg::IDX_COUNT_LO);
    assign hit_ref      = aligned & (reg_index == els_pkg::IDX_REF_CTRL);
    assign hit_line     = aligned & (reg_index == els_pkg::IDX_LINE_IND);
    assign hit_frm      = aligned & (reg_index == els_pkg::IDX_FRM_IND);
    assign hit_link     = aligned & (reg_index == els_pkg::IDX_LINK_IND);
    assign mapped       = hit_enable | hit_flags | hit_cnt_hi | hit_cnt_lo
                        | hit_ref | hit_line | hit_frm | hit_link;
    assign setup_phase  = PSEL & ~PENABLE;
    assign access_phase = PSEL & PENABLE;
    assign write_taken  = access_phase & PWRITE & PSTRB[0] & mapped;

    assign PREADY  = 1'b1;
    assign PSLVERR = access_phase & ~mapped;

    // Write strobes per register; read-only registers ignore writes
    logic       wr_enable;
    logic       wr_flags;
    logic       wr_ref;
    logic [7:0] clear_bits;

    assign wr_enable  = write_taken & hit_enable;
    assign wr_flags   = write_taken & hit_flags;
    assign wr_ref     = write_taken & hit_ref;
    assign clear_bits = wr_flags ? PWDATA[7:0] : 8'h00;

    // Line events
    logic over_high;
    logic over_low;
    logic template_over;
    logic tx_fifo_fault;
    logic rx_fifo_fault;
    logic violation;
    logic count_wrap;
    logic [7:0] events;

    assign over_high     = TEMPLATE_SUM > els_pkg::DAC_LIMIT;
    assign over_low      = TEMPLATE_SUM < -els_pkg::DAC_LIMIT;
    assign template_over = TEMPLATE_CHECK & TEMPLATE_MULTI_UI
                         & (over_high | over_low);
    assign tx_fifo_fault = TX_FIFO_OVERFLOW | TX_FIFO_UNDERFLOW;
    assign rx_fifo_fault = RX_FIFO_OVERFLOW | RX_FIFO_UNDERFLOW;
    assign violation     = BIPOLAR_VIOLATION | CODE_VIOLATION;
    assign count_wrap    = EXCESS_ZEROS & (zero_count == els_pkg::COUNT_MAX);

    always_comb begin
        events = 8'h00;
        events[els_pkg::BIT_TEMPLATE] = template_over;
        events[els_pkg::BIT_TX_FIFO]  = tx_fifo_fault;
        events[els_pkg::BIT_RX_FIFO]  = rx_fifo_fault;
        events[els_pkg::BIT_ZERO]     = EXCESS_ZEROS;
        events[els_pkg::BIT_VIOL]     = violation;
        events[els_pkg::BIT_CNTOV]    = count_wrap;
    end

    // A new event outweighs a clear written in the same cycle
    assign next_flags = ((flags & ~clear_bits) | events) & els_pkg::FLAG_MASK;
    assign next_count = EXCESS_ZEROS ? zero_count + els_pkg::COUNT_STEP
                                     : zero_count;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flags      <= els_pkg::FLAGS_RESET;
            zero_count <= els_pkg::COUNT_RESET;
        end else begin
            flags      <= next_flags;
            zero_count <= next_count;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enable   <= els_pkg::ENABLE_RESET;
            ref_ctrl <= els_pkg::REF_RESET;
        end else begin
            if (wr_enable) begin
                enable <= PWDATA[7:0] & els_pkg::ENABLE_MASK;
            end
            if (wr_ref) begin
                ref_ctrl <= PWDATA[7:0] & (8'h01 << els_pkg::BIT_REF_SEL);
            end
        end
    end

    // Interrupt pin and module indications
    logic [7:0] pending;
    logic [7:0] line_ind;
    logic [7:0] frm_ind;
    logic [7:0] link_ind;

    assign pending = flags & enable;
    assign IRQ     = |pending;

    always_comb begin
        line_ind = 8'h00;
        line_ind[els_pkg::BIT_LINE_IND] = (|LINE_SUB_IRQ) | (|pending);
        frm_ind = {3'h0, FRAMER_IRQ};
        frm_ind[els_pkg::BIT_ALARM] = ALARM_IRQ;
        link_ind = LINK_IRQ;
    end

    // Read data is latched in the setup cycle and stands through the access
    logic [7:0] read_value;

    assign read_value = hit_enable ? enable
                      : hit_flags  ? flags
                      : hit_cnt_hi ? zero_count[15:8]
                      : hit_cnt_lo ? zero_count[7:0]
                      : hit_ref    ? ref_ctrl
                      : hit_line   ? line_ind
                      : hit_frm    ? frm_ind
                      : hit_link   ? link_ind
                      : 8'h00;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_phase) begin
            PRDATA <= (PWRITE ? 32'h0000_0000 : {24'h00_0000, read_value});
        end
    end

    // Reference clock output: master clock, or high during signal loss if selected
    logic ref_hold_high;

    assign ref_hold_high = LOSS_OF_SIGNAL & ref_ctrl[els_pkg::BIT_REF_SEL];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REFERENCE_CLOCK_OUTPUT <= 1'b0;
        end else begin
            REFERENCE_CLOCK_OUTPUT <= ref_hold_high ? 1'b1 : MASTER_CLOCK;
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_flag_clear_write(int b);
        wr_flags && PWDATA[b] && !events[b];
    endsequence

    sequence s_zero_at_max;
        EXCESS_ZEROS && zero_count == els_pkg::COUNT_MAX;
    endsequence

    sequence s_read_of(hit);
        setup_phase && !PWRITE && hit;
    endsequence

    a_template_over_set: assert property (
        (TEMPLATE_CHECK && TEMPLATE_MULTI_UI && (TEMPLATE_SUM > 10'sd63
         || TEMPLATE_SUM < -10'sd63)) |=> flags[6])
        else $error("overrange event did not set flag");

    a_template_in_range: assert property (
        (!flags[6] && !(TEMPLATE_CHECK && TEMPLATE_MULTI_UI
         && (TEMPLATE_SUM > 10'sd63 || TEMPLATE_SUM < -10'sd63))) |=> !flags[6])
        else $error("overrange flag set without cause");

    a_tx_fifo_set: assert property (
        (TX_FIFO_OVERFLOW || TX_FIFO_UNDERFLOW) |=> flags[5])
        else $error("tx fifo fault not flagged");

    a_rx_fifo_set: assert property (
        (RX_FIFO_OVERFLOW || RX_FIFO_UNDERFLOW) |=> flags[4])
        else $error("rx fifo fault not flagged");

    a_zero_error_set: assert property (
        EXCESS_ZEROS |=> flags[2])
        else $error("excess zero error not flagged");

    a_violation_set: assert property (
        (BIPOLAR_VIOLATION || CODE_VIOLATION) |=> flags[1])
        else $error("violation not flagged");

    a_count_wrap_flag: assert property (
        s_zero_at_max |=> flags[0] && zero_count == 16'h0000)
        else $error("counter wrap did not flag overflow");

    a_flag_sticky: assert property (
        (flags[5] && !(wr_flags && PWDATA[5])) |=> flags[5])
        else $error("flag dropped without a clear");

    a_flag_clear: assert property (
        s_flag_clear_write(4) |=> !flags[4])
        else $error("write of one did not clear flag");

    a_set_beats_clear: assert property (
        (wr_flags && PWDATA[1] && violation) |=> flags[1])
        else $error("event lost against clear");

    a_count_read: assert property (
        s_read_of(hit_cnt_hi) |=> PRDATA[7:0] == 8'($past(zero_count) >> 8))
        else $error("high count byte read wrong");

    a_count_step: assert property (
        EXCESS_ZEROS |=> zero_count == $past(zero_count) + 16'h0001)
        else $error("counter did not step by one");

    a_count_hold: assert property (
        !EXCESS_ZEROS |=> $stable(zero_count))
        else $error("counter moved without an error");

    a_ref_high_on_loss: assert property (
        (LOSS_OF_SIGNAL && ref_ctrl[0]) |=> REFERENCE_CLOCK_OUTPUT)
        else $error("reference output not held high");

    a_ref_follows_clock: assert property (
        !(LOSS_OF_SIGNAL && ref_ctrl[0]) |=> REFERENCE_CLOCK_OUTPUT == $past(MASTER_CLOCK))
        else $error("reference output not master clock");

    a_irq_gated: assert property (
        IRQ == |(flags & enable))
        else $error("interrupt pin not gated by enable");

    a_irq_after_event: assert property (
        (enable[els_pkg::BIT_ZERO] && EXCESS_ZEROS && !wr_enable)
        |=> IRQ ##0 ((wr_flags || wr_enable) or (##1 IRQ)))
        else $error("enabled event did not raise interrupt");

    a_line_indication: assert property (
        (|LINE_SUB_IRQ) |-> line_ind[0])
        else $error("line indication missed sub-block");

    a_alarm_indication: assert property (
        frm_ind[5] == ALARM_IRQ)
        else $error("alarm indication mismatch");

    a_framer_indication: assert property (
        frm_ind[4:0] == FRAMER_IRQ && frm_ind[7:6] == 2'h0)
        else $error("framer indication mismatch");

    a_link_indication: assert property (
        link_ind == LINK_IRQ)
        else $error("link indication mismatch");

    a_indication_clears: assert property (
        (LINE_SUB_IRQ == 8'h00 && pending == 8'h00) |-> !line_ind[0])
        else $error("line indication stuck");

    // Register reads, writes and reserved bits
    a_flags_read: assert property (
        s_read_of(hit_flags) |=> PRDATA[7:0] == $past(flags))
        else $error("flag register read wrong");

    a_count_low_read: assert property (
        s_read_of(hit_cnt_lo) |=> PRDATA[7:0] == 8'($past(zero_count)))
        else $error("low count byte read wrong");

    a_line_ind_read: assert property (
        s_read_of(hit_line) |=> PRDATA[7:0] == $past(line_ind))
        else $error("line indication read wrong");

    a_enable_write: assert property (
        wr_enable |=> enable == (els_pkg::ENABLE_MASK & 8'($past(PWDATA))))
        else $error("enable write not taken");

    a_ref_write: assert property (
        wr_ref |=> ref_ctrl == ((8'h01 << els_pkg::BIT_REF_SEL) & 8'($past(PWDATA))))
        else $error("reference select write not taken");

    a_flags_reserved: assert property (
        (flags & ~els_pkg::FLAG_MASK) == 8'h00)
        else $error("reserved flag bit set");

    a_enable_reserved: assert property (
        (enable & ~els_pkg::ENABLE_MASK) == 8'h00)
        else $error("reserved enable bit set");

    a_ref_reserved: assert property (
        (ref_ctrl & ~(8'h01 << els_pkg::BIT_REF_SEL)) == 8'h00)
        else $error("reserved reference bit set");

    // Flags rise only from their own events
    a_tx_fifo_cause: assert property (
        (!flags[els_pkg::BIT_TX_FIFO] && !TX_FIFO_OVERFLOW && !TX_FIFO_UNDERFLOW)
        |=> !flags[els_pkg::BIT_TX_FIFO])
        else $error("tx fifo flag set without cause");

    a_rx_fifo_cause: assert property (
        (!flags[els_pkg::BIT_RX_FIFO] && !RX_FIFO_OVERFLOW && !RX_FIFO_UNDERFLOW)
        |=> !flags[els_pkg::BIT_RX_FIFO])
        else $error("rx fifo flag set without cause");

    a_zero_error_cause: assert property (
        (!flags[els_pkg::BIT_ZERO] && !EXCESS_ZEROS)
        |=> !flags[els_pkg::BIT_ZERO])
        else $error("zero error flag set without cause");

    a_violation_cause: assert property (
        (!flags[els_pkg::BIT_VIOL] && !BIPOLAR_VIOLATION && !CODE_VIOLATION)
        |=> !flags[els_pkg::BIT_VIOL])
        else $error("violation flag set without cause");

    a_overflow_cause: assert property (
        (!flags[els_pkg::BIT_CNTOV] && !(EXCESS_ZEROS && zero_count == els_pkg::COUNT_MAX))
        |=> !flags[els_pkg::BIT_CNTOV])
        else $error("overflow flag set without wrap");

    a_tx_flag_clear: assert property (
        s_flag_clear_write(els_pkg::BIT_TX_FIFO) |=> !flags[els_pkg::BIT_TX_FIFO])
        else $error("write of one did not clear tx fifo flag");

    a_violation_clear: assert property (
        s_flag_clear_write(els_pkg::BIT_VIOL) |=> !flags[els_pkg::BIT_VIOL])
        else $error("write of one did not clear violation flag");

    a_irq_masked: assert property (
        (enable == 8'h00) |-> !IRQ)
        else $error("interrupt raised with all enables off");

    a_line_ind_pending: assert property (
        (|(flags & enable)) |-> line_ind[els_pkg::BIT_LINE_IND])
        else $error("line indication missed pending flag");

endmodule

// ### bench/els_testbench.sv
// Self-checking bench for the line event status block, driven over APB.
// Assumes the design package is compiled first; one clock, no partner model.
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready, pslverr, ref_out, irq;
    logic [7:0]  ev = 8'h00;
    logic        multi = 1'b0, los = 1'b0, mclk = 1'b0, alarm = 1'b0;
    logic signed [9:0] tsum = 10'sd0;
    logic [7:0]  line_irq = 8'h00, link_irq = 8'h00;
    logic [4:0]  frm_irq = 5'h00;
    logic [31:0] rd;
    logic        er;
    int          n_errors = 0, comparisons = 0, exp_cnt = 0;
    int          fbit [8] = '{5, 5, 4, 4, 2, 1, 1, 6};
    int          tcase [4][3] = '{'{63, 1, 0}, '{-63, 1, 0}, '{-64, 1, 1}, '{100, 0, 0}};

    always #4 clk = ~clk;

    els_line_event_status els_line_event_status_inst (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TEMPLATE_CHECK(ev[7]),
        .TEMPLATE_MULTI_UI(multi), .TEMPLATE_SUM(tsum), .TX_FIFO_OVERFLOW(ev[0]),
        .TX_FIFO_UNDERFLOW(ev[1]), .RX_FIFO_OVERFLOW(ev[2]), .RX_FIFO_UNDERFLOW(ev[3]),
        .EXCESS_ZEROS(ev[4]), .BIPOLAR_VIOLATION(ev[5]), .CODE_VIOLATION(ev[6]),
        .LOSS_OF_SIGNAL(los), .MASTER_CLOCK(mclk), .REFERENCE_CLOCK_OUTPUT(ref_out),
        .LINE_SUB_IRQ(line_irq), .ALARM_IRQ(alarm), .FRAMER_IRQ(frm_irq),
        .LINK_IRQ(link_irq), .IRQ(irq));

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, ba(idx), d, 4'hf);
    endtask

    task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, ba(idx), 32'h0, 4'hf);
        chk(nm, rd, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 8'h01 << i;
        @(posedge clk);
        ev <= 8'h00;
        if (i == 4) exp_cnt++;
    endtask

    task automatic close_out;
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        close_out;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("flags reset", els_pkg::IDX_FLAGS, 32'h0);
        rdchk("count hi reset", els_pkg::IDX_COUNT_HI, 32'h0);
        rdchk("count lo reset", els_pkg::IDX_COUNT_LO, 32'h0);
        rdchk("framer ind reset", els_pkg::IDX_FRM_IND, 32'h0);
        rdchk("link ind reset", els_pkg::IDX_LINK_IND, 32'h0);
        // Every event source sets its own sticky bit; a write of one clears it
        tsum <= 10'sd64;
        multi <= 1'b1;
        foreach (fbit[i]) begin
            pulse(i);
            repeat (3) @(posedge clk);
            rdchk("flag set", els_pkg::IDX_FLAGS,
                  32'h1 << fbit[i]);
            wr(els_pkg::IDX_FLAGS, 32'h1 << fbit[i]);
            rdchk("flag cleared", els_pkg::IDX_FLAGS, 32'h0);
        end
        // A clear written while the event fires leaves the flag set
        ev <= 8'h20;
        wr(els_pkg::IDX_FLAGS, 32'h02);
        ev <= 8'h00;
        rdchk("set beats clear", els_pkg::IDX_FLAGS, 32'h02);
        wr(els_pkg::IDX_FLAGS, 32'h02);
        // Template sum limits and the single-UI case
        foreach (tcase[i]) begin
            tsum <= 10'(tcase[i][0]);
            multi <= 1'(tcase[i][1]);
            pulse(7);
            rdchk("overrange", els_pkg::IDX_FLAGS, 32'(tcase[i][2]) << 6);
            wr(els_pkg::IDX_FLAGS, 32'hff);
        end
        // Masked flag, then enabled, write without strobe, then cleared
        pulse(4);
        @(negedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(els_pkg::IDX_ENABLE, 32'hff);
        rdchk("enable mask", els_pkg::IDX_ENABLE, 32'h77);
        wr(els_pkg::IDX_ENABLE, 32'h04);
        @(negedge clk);
        chk("irq enabled", {31'h0, irq}, 32'h1);
        pulse(4);
        @(negedge clk);
        chk("irq held", {31'h0, irq}, 32'h1);
        rdchk("line ind flag", els_pkg::IDX_LINE_IND, 32'h1);
        apb(1'b1, ba(els_pkg::IDX_FLAGS), 32'h04, 4'h0);
        rdchk("no strobe", els_pkg::IDX_FLAGS, 32'h04);
        wr(els_pkg::IDX_FLAGS, 32'h04);
        @(negedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rdchk("line ind clear", els_pkg::IDX_LINE_IND, 32'h0);
        wr(els_pkg::IDX_ENABLE, 32'h00);
        // Counter bytes, read-only, refused addresses
        rdchk("count lo", els_pkg::IDX_COUNT_LO, 32'(exp_cnt));
        wr(els_pkg::IDX_COUNT_LO, 32'hff);
        rdchk("count ro", els_pkg::IDX_COUNT_LO, 32'(exp_cnt));
        apb(1'b0, ba(10'h03a), 32'h0, 4'hf);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, ba(els_pkg::IDX_FLAGS) | 12'h2, 32'h0, 4'hf);
        chk("unaligned err", {31'h0, er}, 32'h1);
        // Run the counter to its wrap point
        @(posedge clk);
        ev <= 8'h10;
        repeat (65536 - exp_cnt - 1) @(posedge clk);
        ev <= 8'h00;
        rdchk("count hi full", els_pkg::IDX_COUNT_HI, 32'hff);
        rdchk("no overflow yet", els_pkg::IDX_FLAGS, 32'h04);
        pulse(4);
        rdchk("count hi wrap", els_pkg::IDX_COUNT_HI, 32'h0);
        rdchk("count lo wrap", els_pkg::IDX_COUNT_LO, 32'h0);
        rdchk("overflow flag", els_pkg::IDX_FLAGS, 32'h05);
        // Reference output during loss of signal
        los <= 1'b1;
        for (int s = 1; s >= 0; s--) begin
            wr(els_pkg::IDX_REF_CTRL, 32'(s));
            rdchk("ref select", els_pkg::IDX_REF_CTRL, 32'(s));
            repeat (6) begin
                @(posedge clk);
                mclk <= ~mclk;
                @(negedge clk);
                chk("ref out", {31'h0, ref_out}, s ? 32'h1 : {31'h0, ~mclk});
            end
        end
        // Without signal loss the select bit leaves the master clock through
        los <= 1'b0;
        wr(els_pkg::IDX_REF_CTRL, 32'h1);
        @(posedge clk);
        mclk <= ~mclk;
        @(negedge clk);
        chk("ref no loss", {31'h0, ref_out}, {31'h0, ~mclk});
        // Module indications follow their sources
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            line_irq <= 8'h01 << i;
            link_irq <= 8'h01 << i;
            frm_irq <= (i < 5) ? 5'(1 << i) : 5'h00;
            alarm <= (i == 5);
            rdchk("line ind", els_pkg::IDX_LINE_IND, 32'h1);
            rdchk("link ind", els_pkg::IDX_LINK_IND, 32'h1 << i);
            rdchk("framer ind", els_pkg::IDX_FRM_IND,
                  (i < 5) ? (32'h1 << i) : ((i == 5) ? 32'h20 : 32'h0));
        end
        @(posedge clk);
        line_irq <= 8'h00;
        link_irq <= 8'h00;
        alarm <= 1'b0;
        rdchk("line ind off", els_pkg::IDX_LINE_IND, 32'h0);
        rdchk("link ind off", els_pkg::IDX_LINK_IND, 32'h0);
        close_out;
    end
endmodule
